// >>> hdl/test_access_defines.vh
// Constants for the test register access and observation block.
// Function
// - Test registers sit outside the ordinary map; reachable only after test access.
// - Test access command opens test registers for read and write.
// - Test access then register reads or writes chain in one frame, address auto-increments.
// - Select line toggling resets the serial logic but keeps test register contents.
// - Test registers return to default at power-up and on clear command.
// - The two observation pins carry observation signals when a mode is selected.
// - Observation register at test address 01h: bits 7-5 reserved, bit 4 unused, default zero.
// - Observation modes in the low four bits work in normal operation too.
// - Other observation modes also work without analog test mode.
// - Code 0100 gives digitized AM and PM; 0001-0011, 0101 select analog variants.
// - Code 1001 gives channel selection and collision avoidance detector output.
// - Code 1010 gives transmit modulation and PM-select signals.
// - At power-up the device is powered down with all registers at default.
// - Calibration commands are accepted only when enabled and oscillator is stable.
`ifndef TEST_ACCESS_DEFINES_VH
`define TEST_ACCESS_DEFINES_VH
`define OBS_SEL_ADDR      6'h01
`define OBS_SEL_RESET     8'h00
`define OBS_SEL_WMASK     8'h0f
`define CMD_TEST_ACCESS   8'hfc
`define CMD_CLEAR_TEST    8'hfa
`define CMD_CAL_ANTENNA   8'hd8
`define CMD_CAL_MOD       8'hd7
`define CMD_ADJ_REG       8'hd6
`define MODE_AM_ANA       4'h1
`define MODE_PM_ANA       4'h2
`define MODE_AMPM_ANA     4'h3
`define MODE_AMPM_DIG     4'h4
`define MODE_STAGES       4'h5
`define MODE_CHSEL_CA     4'h9
`define MODE_TXMOD_PMSEL  4'ha
`endif

// >>> hdl/sync2.v
// Two flip-flop synchroniser for a bus of levels.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter W = 1
) (
    input  wire         ref_clk,
    input  wire         rst_n,
    input  wire         en,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
        end
        else if (en)
        begin
            s1_q <= d;
            s2_q <= s1_q;
        end
    end
    assign q = s2_q;
endmodule
`default_nettype wire

// >>> hdl/test_access.v
// Test register access over the serial port and the observation pin multiplexer.
`timescale 1ns/1ps
`default_nettype none
`include "test_access_defines.vh"
module test_access (
    input  wire       ref_clk,
    input  wire       reset_n,
    input  wire       clk_en,
    input  wire       spi_ss_n,
    input  wire       spi_sclk,
    input  wire       spi_mosi,
    output reg        spi_miso,
    output wire       spi_miso_oe,
    input  wire       op_enable,
    input  wire       osc_stable,
    input  wire       am_analog,
    input  wire       pm_analog,
    input  wire       am_digital,
    input  wire       pm_digital,
    input  wire       stage1_analog,
    input  wire       stage2_analog,
    input  wire       chan_select,
    input  wire       ca_detect,
    input  wire       ca_enabled,
    input  wire       tx_mod,
    input  wire       pm_select,
    input  wire       pin_a_normal,
    input  wire       pin_b_normal,
    output reg        observe_pin_a,
    output reg        observe_pin_b,
    output reg        observe_active,
    output reg        cal_antenna_go,
    output reg        cal_mod_go,
    output reg        adj_reg_go,
    output wire       test_access_open
);
    // ==========================================================
    // Reset release and pin synchronisers.
    reg rs1_q;
    reg rst_q;
    always @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rs1_q <= 1'b0;
            rst_q <= 1'b0;
        end
        else
        begin
            rs1_q <= 1'b1;
            rst_q <= rs1_q;
        end
    end
    // Select travels inverted so that the synchroniser resets to the deselected level.
    wire [2:0] pins_s;
    sync2 #(.W(3)) u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_q),
        .en      (clk_en),
        .d       ({~spi_ss_n, spi_sclk, spi_mosi}),
        .q       (pins_s)
    );
    wire ss_n_s = ~pins_s[2];
    wire sclk_s = pins_s[1];
    wire mosi_s = pins_s[0];
    reg  sclk_q;
    always @(posedge ref_clk or negedge rst_q)
    begin
        if (!rst_q)
            sclk_q <= 1'b0;
        else if (clk_en)
            sclk_q <= sclk_s;
    end
    wire rise = clk_en & ~ss_n_s & sclk_s & ~sclk_q;
    wire fall = clk_en & ~ss_n_s & ~sclk_s & sclk_q;
    // ==========================================================
    // Serial frame decoder: first byte is a command or register access.
    localparam ST_CMD = 3'b001;
    localparam ST_WR  = 3'b010;
    localparam ST_RD  = 3'b100;
    reg [2:0] st_q;
    reg [2:0] bit_q;
    reg [7:0] sh_q;
    reg [5:0] addr_q;
    reg       test_q;
    reg [7:0] obs_q;
    reg [7:0] tx_q;
    wire [7:0] byte_in = {sh_q[6:0], mosi_s};
    wire       byte_done = rise & (bit_q == 3'h7);
    wire       hit = test_q & (addr_q == `OBS_SEL_ADDR);
    wire       cal_ok = op_enable & osc_stable;
    assign test_access_open = test_q;
    assign spi_miso_oe = ~ss_n_s & st_q[2];
    always @(posedge ref_clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            st_q   <= ST_CMD;
            bit_q  <= 3'h0;
            sh_q   <= 8'h00;
            addr_q <= 6'h00;
            test_q <= 1'b0;
            obs_q  <= `OBS_SEL_RESET;
            tx_q   <= 8'h00;
            cal_antenna_go <= 1'b0;
            cal_mod_go     <= 1'b0;
            adj_reg_go     <= 1'b0;
        end
        else if (clk_en)
        begin
            cal_antenna_go <= 1'b0;
            cal_mod_go     <= 1'b0;
            adj_reg_go     <= 1'b0;
            if (ss_n_s)
            begin
                // Serial logic resets; obs_q is left alone.
                st_q   <= ST_CMD;
                bit_q  <= 3'h0;
                test_q <= 1'b0;
            end
            else
            begin
                if (rise)
                begin
                    sh_q  <= byte_in;
                    bit_q <= bit_q + 3'h1;
                end
                if (byte_done)
                begin
                    case (st_q)
                        ST_CMD:
                        begin
                            if (byte_in[7:6] == 2'b11)
                            begin
                                if (byte_in == `CMD_TEST_ACCESS)
                                    test_q <= 1'b1;
                                else if (byte_in == `CMD_CLEAR_TEST)
                                    obs_q <= `OBS_SEL_RESET;
                                else if (byte_in == `CMD_CAL_ANTENNA)
                                    cal_antenna_go <= cal_ok;
                                else if (byte_in == `CMD_CAL_MOD)
                                    cal_mod_go <= cal_ok;
                                else if (byte_in == `CMD_ADJ_REG)
                                    adj_reg_go <= cal_ok;
                            end
                            else
                            begin
                                addr_q <= byte_in[5:0];
                                if (byte_in[6])
                                begin
                                    st_q <= ST_RD;
                                    tx_q <= (test_q && byte_in[5:0] == `OBS_SEL_ADDR) ? obs_q : 8'h00;
                                end
                                else
                                    st_q <= ST_WR;
                            end
                        end
                        ST_WR:
                        begin
                            if (hit)
                                obs_q <= byte_in & `OBS_SEL_WMASK;
                            addr_q <= addr_q + 6'h01;
                        end
                        ST_RD:
                        begin
                            addr_q <= addr_q + 6'h01;
                            tx_q <= (test_q && (addr_q + 6'h01) == `OBS_SEL_ADDR) ? obs_q : 8'h00;
                        end
                        default:
                            st_q <= ST_CMD;
                    endcase
                end
                else if (fall && st_q == ST_RD && bit_q != 3'h0)
                    tx_q <= {tx_q[6:0], 1'b0}; // The first fall after a load keeps the MSB on the line.
            end
        end
    end
    always @(posedge ref_clk or negedge rst_q)
    begin
        if (!rst_q)
            spi_miso <= 1'b0;
        else if (clk_en)
            spi_miso <= tx_q[7];
    end
    // ==========================================================
    // Observation multiplexer, active in normal and test operation.
    always @(posedge ref_clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            observe_pin_a  <= 1'b0;
            observe_pin_b  <= 1'b0;
            observe_active <= 1'b0;
        end
        else if (clk_en)
        begin
            observe_active <= 1'b1;
            case (obs_q[3:0])
                `MODE_AM_ANA:
                begin
                    observe_pin_a <= am_analog;
                    observe_pin_b <= am_digital;
                end
                `MODE_PM_ANA:
                begin
                    observe_pin_a <= pm_analog;
                    observe_pin_b <= pm_digital;
                end
                `MODE_AMPM_ANA:
                begin
                    observe_pin_a <= am_analog;
                    observe_pin_b <= pm_analog;
                end
                `MODE_AMPM_DIG:
                begin
                    observe_pin_a <= am_digital;
                    observe_pin_b <= pm_digital;
                end
                `MODE_STAGES:
                begin
                    observe_pin_a <= stage1_analog;
                    observe_pin_b <= stage2_analog;
                end
                `MODE_CHSEL_CA:
                begin
                    observe_pin_a <= chan_select;
                    observe_pin_b <= ca_detect & ca_enabled;
                end
                `MODE_TXMOD_PMSEL:
                begin
                    observe_pin_a <= tx_mod;
                    observe_pin_b <= pm_select;
                end
                default:
                begin
                    observe_active <= 1'b0;
                    observe_pin_a  <= pin_a_normal;
                    observe_pin_b  <= pin_b_normal;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> sim/test_access_monitor.sv
// Port assertions for the test access block.
`timescale 1ns/1ps
`default_nettype none
module test_access_monitor (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic op_enable,
    input wire logic osc_stable,
    input wire logic spi_ss_n,
    input wire logic spi_miso_oe,
    input wire logic pin_a_normal,
    input wire logic pin_b_normal,
    input wire logic observe_pin_a,
    input wire logic observe_pin_b,
    input wire logic observe_active,
    input wire logic cal_antenna_go,
    input wire logic cal_mod_go,
    input wire logic adj_reg_go,
    input wire logic test_access_open
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    chk_reset_clear: assert property ($rose(reset_n) |-> !observe_active && !test_access_open)
        else $error("outputs active right after reset");
    chk_antenna_gate: assert property (cal_antenna_go |-> op_enable && osc_stable)
        else $error("antenna calibration while disabled");
    chk_mod_gate: assert property (cal_mod_go |-> op_enable && osc_stable)
        else $error("modulation calibration while disabled");
    chk_adj_gate: assert property (adj_reg_go |-> op_enable && osc_stable)
        else $error("regulator adjust while disabled");
    chk_pulse_single: assert property (cal_antenna_go || cal_mod_go || adj_reg_go |=> !(cal_antenna_go || cal_mod_go || adj_reg_go))
        else $error("command pulse longer than one cycle");
    chk_open_cause: assert property ($rose(test_access_open) |-> !spi_ss_n && !$past(spi_ss_n, 3))
        else $error("test access opened outside a frame");
    chk_open_holds: assert property (test_access_open && !spi_ss_n |=> test_access_open)
        else $error("test access lost inside a frame");
    chk_open_closes: assert property (spi_ss_n [*6] |-> !test_access_open)
        else $error("test access left open after frame");
    chk_oe_closes: assert property (spi_ss_n [*6] |-> !spi_miso_oe)
        else $error("serial output driven outside a frame");
    chk_pins_normal: assert property (!observe_active && $stable(pin_a_normal) && $stable(pin_b_normal)
        |-> observe_pin_a == pin_a_normal && observe_pin_b == pin_b_normal)
        else $error("observation pins not in normal function");
    cover property (cal_antenna_go);
    cover property ($rose(test_access_open));
    cover property (observe_active && observe_pin_a);
endmodule
bind test_access test_access_monitor i_mon (.ref_clk, .reset_n, .op_enable, .osc_stable, .spi_ss_n, .spi_miso_oe,
    .pin_a_normal, .pin_b_normal, .observe_pin_a, .observe_pin_b, .observe_active, .cal_antenna_go, .cal_mod_go,
    .adj_reg_go, .test_access_open);
`default_nettype wire

// >>> sim/spi_host_model.sv
// Host controller model driving the serial port.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input  wire logic ref_clk,
    input  wire logic spi_miso,
    output var logic  spi_ss_n,
    output var logic  spi_sclk,
    output var logic  spi_mosi
);
    initial {spi_ss_n, spi_sclk, spi_mosi} = 3'b101;
    // Opens one chained frame that lasts until frame_end.
    task automatic frame_begin;
        @(posedge ref_clk);
        spi_ss_n <= 1'b0;
        repeat (10) @(posedge ref_clk);
    endtask
    // Sends one byte MSB first in mode 0 and returns the byte read back.
    task automatic xfer(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--)
        begin
            spi_sclk <= 1'b0;
            spi_mosi <= b[i];
            repeat (10) @(posedge ref_clk);
            r[i] = spi_miso;
            spi_sclk <= 1'b1;
            repeat (10) @(posedge ref_clk);
        end
    endtask
    // Closes the frame and lets the released data line wander.
    task automatic frame_end;
        spi_sclk <= 1'b0;
        repeat (10) @(posedge ref_clk);
        spi_ss_n <= 1'b1;
        spi_mosi <= ~spi_mosi;
        repeat (20) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// >>> sim/test_access_tb.sv
// Self-checking testbench for the test access block.
`timescale 1ns/1ps
`default_nettype none
module test_access_tb;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        clk_en = 1'b1;
    logic        op_enable = 1'b0;
    logic        osc_stable = 1'b0;
    logic        pin_a_normal = 1'b0;
    logic        pin_b_normal = 1'b0;
    logic [10:0] src = 11'h000;
    logic [2:0]  seen = 3'h0;
    logic        seen_clr = 1'b0;
    logic [7:0]  rd;
    int          failures = 0;
    int          tests_run = 0;
    wire logic   spi_ss_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe, observe_pin_a, observe_pin_b;
    wire logic   observe_active, cal_antenna_go, cal_mod_go, adj_reg_go, test_access_open;
    test_access i_dut (.ref_clk, .reset_n, .clk_en, .spi_ss_n, .spi_sclk, .spi_mosi, .spi_miso, .spi_miso_oe,
        .op_enable, .osc_stable, .am_analog(src[10]), .pm_analog(src[9]), .am_digital(src[8]), .pm_digital(src[7]),
        .stage1_analog(src[6]), .stage2_analog(src[5]), .chan_select(src[4]), .ca_detect(src[3]),
        .ca_enabled(src[2]), .tx_mod(src[1]), .pm_select(src[0]), .pin_a_normal, .pin_b_normal, .observe_pin_a,
        .observe_pin_b, .observe_active, .cal_antenna_go, .cal_mod_go, .adj_reg_go, .test_access_open);
    spi_host_model i_host (.ref_clk, .spi_miso, .spi_ss_n, .spi_sclk, .spi_mosi);
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
        if (seen_clr)
            seen <= 3'h0;
        else if (cal_mod_go || cal_antenna_go || adj_reg_go)
            seen <= {cal_mod_go, cal_antenna_go, adj_reg_go};
    function automatic logic [2:0] pins(input logic [3:0] m);
        case (m)
            4'h1: return {1'b1, src[10], src[8]};
            4'h2: return {1'b1, src[9], src[7]};
            4'h3: return {1'b1, src[10], src[9]};
            4'h4: return {1'b1, src[8], src[7]};
            4'h5: return {1'b1, src[6], src[5]};
            4'h9: return {1'b1, src[4], src[3] & src[2]};
            4'ha: return {1'b1, src[1], src[0]};
            default: return {1'b0, pin_a_normal, pin_b_normal};
        endcase
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic frame(input logic [31:0] bytes, input int n);
        i_host.frame_begin;
        for (int i = n - 1; i >= 0; i--)
            i_host.xfer(bytes[8*i +: 8], rd);
        i_host.frame_end;
    endtask
    task automatic t_modes;
        logic [7:0] codes [10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h09, 8'h0a, 8'h00, 8'h06, 8'hf9};
        for (int c = 0; c < 10; c++)
        begin
            frame({8'hfc, 8'h01, codes[c]}, 3);
            for (int p = 0; p < 3; p++)
            begin
                src <= (p == 0) ? 11'h5a6 : (p == 1) ? ~11'h5a6 : 11'h10c;
                {pin_a_normal, pin_b_normal} <= (p == 0) ? 2'b10 : (p == 1) ? 2'b01 : 2'b11;
                repeat (4) @(posedge ref_clk);
                check({5'h0, observe_active, observe_pin_a, observe_pin_b}, {5'h0, pins(codes[c][3:0])}, "pins");
            end
            frame({8'hfc, 8'h41, 8'h00}, 3);
            check(rd, codes[c] & 8'h0f, "readback");
        end
        $display("test modes done");
    endtask
    task automatic t_refuse;
        frame({8'hfc, 8'h01, 8'h05}, 3);
        frame({8'h01, 8'h0a}, 2);
        frame({8'hfc, 8'h41, 8'h00}, 3);
        check(rd, 8'h05, "write without access");
        frame({8'h41, 8'h00}, 2);
        check(rd, 8'h00, "read without access");
        frame({8'hfc, 8'h00, 8'h77, 8'h0c}, 4);
        frame({8'hfc, 8'h40, 8'h00, 8'h00}, 4);
        check(rd, 8'h0c, "auto increment");
        frame(8'hfa, 1);
        frame({8'hfc, 8'h41, 8'h00}, 3);
        check(rd, 8'h00, "clear");
        $display("test access rules done");
    endtask
    task automatic t_cal;
        logic [7:0] cmd [3] = '{8'hd6, 8'hd8, 8'hd7};
        for (int e = 0; e < 4; e++)
            for (int k = 0; k < 3; k++)
            begin
                {op_enable, osc_stable} <= e[1:0];
                seen_clr <= 1'b1;
                @(posedge ref_clk);
                seen_clr <= 1'b0;
                frame(cmd[k], 1);
                check({5'h0, seen}, (e == 3) ? 8'h01 << k : 8'h00, "calibration pulse");
            end
        $display("test calibration done");
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        frame({8'h00, 8'h00, 8'h00}, 3);
        frame({8'hfc, 8'h41, 8'h00}, 3);
        check(rd, 8'h00, "power-up value");
        $display("test power-up done");
        t_modes;
        t_refuse;
        t_cal;
        test_done;
    end
    initial
    begin
        #400000;
        failures++;
        test_done;
    end
endmodule
`default_nettype wire
